// ==== verilog/asl_lock_cmd.sv ====
// security lock command handler: disable password, erase prepare, erase unit
// assumes the host side logic shares ref_clk and honours cmdReady and dataReady
`timescale 1ns/1ps
module asl_lock_cmd
    import asl_pkg::*;
#(
    parameter logic [7:0] FORMAT_OPCODE = 8'hF7
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // command register write
    input wire logic cmdValid,
    input wire logic [7:0] cmdCode,
    output logic cmdReady,
    // parameter sector words from the host
    input wire logic dataValid,
    input wire logic [15:0] dataWord,
    output logic dataReady,
    // password load from the set password path
    input wire logic pwSetValid,
    input wire logic pwSetMaster,
    input wire logic [PW_BITS-1:0] pwSetValue,
    // completion and state
    output logic cmdDone,
    output logic [7:0] command_status_flags,
    output logic [7:0] command_error_flags,
    output logic lockEnabled,
    output logic eraseStart
);
    // a format opcode equal to a security opcode would make the decode ambiguous
    if (FORMAT_OPCODE == OP_DISABLE || FORMAT_OPCODE == OP_PREPARE ||
        FORMAT_OPCODE == OP_ERASE) begin
        $error("format opcode collides with a security opcode");
    end

    // ======================================================
    // state
    asl_state_t state, next_state;
    logic [7:0] wordCnt, next_wordCnt;
    logic [7:0] curOp, next_curOp;
    logic selMaster, next_selMaster;
    logic mismatch, next_mismatch;
    logic pendingPrep, next_pendingPrep;
    logic [PW_BITS-1:0] userPw, next_userPw;
    logic [PW_BITS-1:0] masterPw, next_masterPw;
    logic next_lockEnabled, next_cmdDone, next_eraseStart;
    logic [7:0] next_status, next_error;
    logic [15:0] refWord;
    logic [3:0] pwIdx;

    // handshakes are plain decodes of the state
    assign cmdReady = (state == ASL_IDLE);
    assign dataReady = (state == ASL_XFER);
    assign pwIdx = 4'(wordCnt - PW_FIRST);
    assign refWord = selMaster ? masterPw[pwIdx*16 +: 16] : userPw[pwIdx*16 +: 16];

    // ======================================================
    // next state: command decode, sector intake and evaluation
    always_comb begin
        logic abort;
        logic finish;
        abort = 1'b0;
        finish = 1'b0;
        next_state = state;
        next_wordCnt = wordCnt;
        next_curOp = curOp;
        next_selMaster = selMaster;
        next_mismatch = mismatch;
        next_pendingPrep = pendingPrep;
        next_userPw = userPw;
        next_masterPw = masterPw;
        next_lockEnabled = lockEnabled;
        next_status = command_status_flags;
        next_error = command_error_flags;
        next_eraseStart = 1'b0;
        case (state)
            ASL_IDLE: begin
                if (cmdValid) begin
                    next_curOp = cmdCode;
                    // any command but erase unit or format drops the armed prepare
                    if (cmdCode != OP_ERASE && cmdCode != FORMAT_OPCODE) begin
                        next_pendingPrep = 1'b0;
                    end
                    if (cmdCode == OP_PREPARE) begin
                        next_pendingPrep = 1'b1;
                        finish = 1'b1;
                    end else if (cmdCode == OP_ERASE && !pendingPrep) begin
                        abort = 1'b1;
                        finish = 1'b1;
                    end else if (cmdCode == OP_DISABLE || cmdCode == OP_ERASE) begin
                        // open the one-sector data phase
                        next_pendingPrep = 1'b0;
                        next_state = ASL_XFER;
                        next_wordCnt = 8'h00;
                        next_mismatch = 1'b0;
                        next_status = 8'h00;
                        next_status[ST_READY] = 1'b1;
                        next_status[ST_DSC] = 1'b1;
                        next_status[ST_DRQ] = 1'b1;
                        next_error = ERROR_RST;
                    end
                end
            end
            ASL_XFER: begin
                if (dataValid) begin
                    next_wordCnt = wordCnt + 8'h01;
                    if (wordCnt == 8'h00) begin
                        next_selMaster = dataWord[ID_BIT];
                    end else if (wordCnt <= PW_LAST && dataWord != refWord) begin
                        next_mismatch = 1'b1;
                    end
                    if (wordCnt == LAST_WORD) begin
                        next_state = ASL_IDLE;
                        finish = 1'b1;
                        if (!lockEnabled && !selMaster) begin
                            abort = 1'b1;
                        end else if (curOp == OP_DISABLE) begin
                            if (mismatch) begin
                                abort = 1'b1;
                            end else begin
                                next_lockEnabled = 1'b0;
                            end
                        end else if (lockEnabled && mismatch) begin
                            abort = 1'b1;
                        end else begin
                            // with security off the password is not compared
                            next_lockEnabled = 1'b0;
                            next_eraseStart = 1'b1;
                        end
                    end
                end
            end
            default: next_state = ASL_IDLE;
        endcase
        // completion image of status and error
        if (finish) begin
            next_status = 8'h00;
            next_status[ST_READY] = 1'b1;
            next_status[ST_DSC] = 1'b1;
            next_status[ST_ERR] = abort;
            next_error = ERROR_RST;
            next_error[ER_ABORT] = abort;
        end
        // only a new user password arms the lock; master load leaves it alone
        if (pwSetValid) begin
            if (pwSetMaster) begin
                next_masterPw = pwSetValue;
            end else begin
                next_userPw = pwSetValue;
                next_lockEnabled = 1'b1;
            end
        end
        next_cmdDone = finish;
    end

    // registers only
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= ASL_IDLE;
            wordCnt <= 8'h00;
            curOp <= 8'h00;
            selMaster <= 1'b0;
            mismatch <= 1'b0;
            pendingPrep <= 1'b0;
            userPw <= '0;
            masterPw <= '0;
            lockEnabled <= 1'b0;
            command_status_flags <= STATUS_RST;
            command_error_flags <= ERROR_RST;
            cmdDone <= 1'b0;
            eraseStart <= 1'b0;
        end else begin
            state <= next_state;
            wordCnt <= next_wordCnt;
            curOp <= next_curOp;
            selMaster <= next_selMaster;
            mismatch <= next_mismatch;
            pendingPrep <= next_pendingPrep;
            userPw <= next_userPw;
            masterPw <= next_masterPw;
            lockEnabled <= next_lockEnabled;
            command_status_flags <= next_status;
            command_error_flags <= next_error;
            cmdDone <= next_cmdDone;
            eraseStart <= next_eraseStart;
        end
    end

    // ======================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence take_s(logic [7:0] op);
        cmdValid && cmdReady && cmdCode == op;
    endsequence
    sequence last_word_s;
        dataValid && dataReady && wordCnt == LAST_WORD;
    endsequence

    disable_xfer_a: assert property (take_s(OP_DISABLE) |=>
        command_status_flags[ST_DRQ] && !cmdDone)
        else $error("disable did not open a data phase");
    sector_end_a: assert property (last_word_s |=> cmdDone && !dataReady)
        else $error("sector end did not complete the command");
    early_done_a: assert property (dataReady && cmdDone |-> 1'b0)
        else $error("completion during data phase");
    off_user_a: assert property (last_word_s ##0 (!lockEnabled && !selMaster)
        |=> command_error_flags[ER_ABORT] && command_status_flags[ST_ERR])
        else $error("user disable with security off not aborted");
    unlock_cause_a: assert property ($fell(lockEnabled) |->
        cmdDone && !command_error_flags[ER_ABORT] && !$past(mismatch))
        else $error("lock dropped without a matching password");
    master_keep_a: assert property ($changed(masterPw) |->
        $past(pwSetValid) && $past(pwSetMaster))
        else $error("master password changed by a command");
    prepare_fast_a: assert property (take_s(OP_PREPARE) |=>
        cmdDone && pendingPrep && !command_status_flags[ST_DRQ] && !eraseStart)
        else $error("prepare did not complete at once");
    erase_unarmed_a: assert property (take_s(OP_ERASE) ##0 !pendingPrep
        |=> cmdDone && command_error_flags[ER_ABORT] && !dataReady)
        else $error("unprepared erase not aborted");
    erase_mismatch_a: assert property (last_word_s ##0 (curOp == OP_ERASE &&
        lockEnabled && mismatch) |=> command_error_flags[ER_ABORT] && !eraseStart)
        else $error("erase with bad password not aborted");
    done_clean_a: assert property (cmdDone |-> !command_status_flags[ST_BUSY] &&
        !command_status_flags[ST_DF] &&
        command_status_flags[ST_ERR] == command_error_flags[ER_ABORT])
        else $error("completion status inconsistent");
    pending_drop_a: assert property (cmdValid && cmdReady && cmdCode != OP_PREPARE &&
        cmdCode != OP_ERASE && cmdCode != FORMAT_OPCODE |=> !pendingPrep)
        else $error("pending prepare survived another command");
endmodule

// ==== verilog/asl_pkg.sv ====
// shared constants for the security lock command handler
// assumes the command block registers are driven by logic on the same clock
package asl_pkg;
    // ======================================================
    // command opcodes
    localparam logic [7:0] OP_DISABLE = 8'hF6;
    localparam logic [7:0] OP_PREPARE = 8'hF3;
    localparam logic [7:0] OP_ERASE = 8'hF4;
    // ======================================================
    // parameter sector layout, in 16-bit words
    localparam int SECTOR_WORDS = 256;
    localparam logic [7:0] LAST_WORD = 8'hFF;
    localparam logic [7:0] PW_FIRST = 8'h01;
    localparam logic [7:0] PW_LAST = 8'h10;
    localparam int PW_BITS = 256;
    localparam int ID_BIT = 0;
    // ======================================================
    // status and error bit positions
    localparam int ST_BUSY = 7;
    localparam int ST_READY = 6;
    localparam int ST_DF = 5;
    localparam int ST_DSC = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam int ER_IDN = 4;
    localparam int ER_ABORT = 2;
    // ======================================================
    // reset values
    localparam logic [7:0] STATUS_RST = 8'h50;
    localparam logic [7:0] ERROR_RST = 8'h00;
    // ======================================================
    // sequencer states
    typedef enum logic [0:0] {
        ASL_IDLE,
        ASL_XFER
    } asl_state_t;
endpackage

// ==== bench/asl_host_model.sv ====
// host controller model: command writes and one parameter sector per data phase
// assumes ref_clk is shared with the handler; every change lands on a falling edge
`timescale 1ns/1ps
module asl_host_model
    import asl_pkg::*;
(
    // clock and handshakes
    input wire logic ref_clk,
    input wire logic cmdReady,
    input wire logic dataReady,
    // towards the handler, plus the stuck flag for the bench
    output logic cmdValid,
    output logic [7:0] cmdCode,
    output logic dataValid,
    output logic [15:0] dataWord,
    output logic stuck
);
    // quiet bus at time zero
    initial begin
        cmdValid = 1'b0;
        cmdCode = 8'h00;
        dataValid = 1'b0;
        dataWord = 16'h0000;
        stuck = 1'b0;
    end
    // ====
    // command write; ready is read before the edge so no race with the state register
    task automatic issue(input logic [7:0] code);
        int n;
        @(negedge ref_clk);
        cmdValid = 1'b1;
        cmdCode = code;
        n = 0;
        while (!cmdReady && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        stuck |= !cmdReady;
        @(negedge ref_clk);
        cmdValid = 1'b0;
        cmdCode = ~code; // released bus shows no stale opcode
    endtask
    // ====
    // one whole sector; fill seeds reserved words and idle gaps between words
    task automatic sector(input logic [15:0] w0, input logic [255:0] pw, input logic [15:0] fill);
        int n;
        for (int k = 0; k < SECTOR_WORDS; k++) begin
            n = 0;
            while (!dataReady && n < 50) begin
                @(negedge ref_clk);
                n++;
            end
            stuck |= !dataReady;
            dataValid = 1'b1;
            dataWord = (k == 0) ? w0 : (k <= 16) ? pw[(k-1)*16 +: 16] : fill ^ k[15:0];
            @(negedge ref_clk);
            if (fill[k % 16] && k < 255) begin
                dataValid = 1'b0;
                dataWord = ~dataWord;
                @(negedge ref_clk);
            end
        end
        dataValid = 1'b0;
        dataWord = ~dataWord;
    endtask
endmodule

// ==== bench/tb_top.sv ====
// self-checking bench for the security lock command handler
// assumes asl_pkg is compiled first; the host model owns the command and data lines
`timescale 1ns/1ps
module tb_top
    import asl_pkg::*;
;
    logic ref_clk, rst, cmdValid, cmdReady, dataValid, dataReady, pwSetValid, pwSetMaster;
    logic cmdDone, lockEnabled, eraseStart, stuck, lk, ok;
    logic [7:0] cmdCode, command_status_flags, command_error_flags;
    logic [15:0] dataWord, seed;
    logic [255:0] pwSetValue, pwU, pwM, pwX, pw;
    int n_fail, compares;
    asl_lock_cmd asl_lock_cmd_i (.ref_clk(ref_clk), .rst(rst), .cmdValid(cmdValid),
        .cmdCode(cmdCode), .cmdReady(cmdReady), .dataValid(dataValid), .dataWord(dataWord),
        .dataReady(dataReady), .pwSetValid(pwSetValid), .pwSetMaster(pwSetMaster),
        .pwSetValue(pwSetValue), .cmdDone(cmdDone), .command_status_flags(command_status_flags),
        .command_error_flags(command_error_flags), .lockEnabled(lockEnabled),
        .eraseStart(eraseStart));
    asl_host_model asl_host_model_i (.ref_clk(ref_clk), .cmdReady(cmdReady),
        .dataReady(dataReady), .cmdValid(cmdValid), .cmdCode(cmdCode), .dataValid(dataValid),
        .dataWord(dataWord), .stuck(stuck));
    // 125 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // ====
    // expectations and random source
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] exp_status(input logic ab);
        return STATUS_RST | (8'(ab) << ST_ERR);
    endfunction
    function automatic logic [7:0] exp_error(input logic ab);
        return ERROR_RST | (8'(ab) << ER_ABORT);
    endfunction
    function automatic logic [255:0] rand_pw();
        logic [255:0] p;
        for (int k = 0; k < 16; k++) begin
            seed = lfsr(seed);
            p[k*16 +: 16] = seed;
        end
        return p;
    endfunction
    // ====
    // compare, verdict
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wrap_up();
        if (stuck) n_fail++;
        $display("counts: %0d compares, %0d mismatches", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ====
    // stored password load, one pulse
    task automatic setpw(input logic m, input logic [255:0] v);
        @(negedge ref_clk);
        pwSetValid = 1'b1;
        pwSetMaster = m;
        pwSetValue = v;
        @(negedge ref_clk);
        pwSetValid = 1'b0;
    endtask
    // one command end to end; the registered answer stands only in the cycle right after
    // the take or the last word, so it is looked at on the falling edge that follows
    task automatic op(input logic [7:0] code, input logic data, input logic [15:0] w0,
        input logic [255:0] p, input logic ab, input logic lkx, input logic er);
        int n;
        asl_host_model_i.issue(code);
        seed = lfsr(seed);
        if (data) begin
            // data phase is open from the take edge on
            chk(command_status_flags, STATUS_RST | (8'h01 << ST_DRQ), "phase status");
            chk({6'h00, cmdReady, dataReady}, 8'h01, "phase handshakes");
            asl_host_model_i.sector(w0, p, seed);
        end
        n = 0;
        while (cmdDone !== 1'b1 && n < 4) begin
            @(negedge ref_clk);
            n++;
        end
        chk(8'(n), 8'h00, "answer delay");
        if (cmdDone !== 1'b1) wrap_up();
        chk({6'h00, cmdReady, dataReady}, 8'h02, "idle handshakes");
        chk(command_status_flags, exp_status(ab), "status");
        chk(command_error_flags, exp_error(ab), "error");
        chk({7'h00, lockEnabled}, {7'h00, lkx}, "lock");
        chk({7'h00, eraseStart}, {7'h00, er}, "erase start");
        $display("test opcode %h done at %0t", code, $time);
    endtask
    // ====
    // main sequence: hand-picked corners, then random disable traffic
    initial begin
        rst = 1'b1;
        pwSetValid = 1'b0;
        pwSetMaster = 1'b0;
        pwSetValue = '0;
        seed = 16'h41D0;
        n_fail = 0;
        compares = 0;
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        chk(command_status_flags, STATUS_RST, "reset status");
        pwU = rand_pw();
        pwM = rand_pw();
        pwX = rand_pw();
        setpw(1'b1, pwM);
        setpw(1'b0, pwU);
        op(OP_DISABLE, 1'b1, 16'hFFFF, pwU, 1'b1, 1'b1, 1'b0);
        op(OP_DISABLE, 1'b1, 16'hA5A4, pwU, 1'b0, 1'b0, 1'b0);
        op(OP_DISABLE, 1'b1, 16'h0000, pwU, 1'b1, 1'b0, 1'b0);
        setpw(1'b0, pwU);
        op(OP_DISABLE, 1'b1, 16'h0001, pwM, 1'b0, 1'b0, 1'b0);
        setpw(1'b0, pwU);
        op(OP_ERASE, 1'b0, 16'h0001, pwM, 1'b1, 1'b1, 1'b0);
        op(OP_PREPARE, 1'b0, 16'h0000, pwX, 1'b0, 1'b1, 1'b0);
        op(OP_ERASE, 1'b1, 16'h0001, pwX, 1'b1, 1'b1, 1'b0);
        op(OP_PREPARE, 1'b0, 16'h0000, pwX, 1'b0, 1'b1, 1'b0);
        asl_host_model_i.issue(8'hEC);
        op(OP_ERASE, 1'b0, 16'h0001, pwM, 1'b1, 1'b1, 1'b0);
        op(OP_PREPARE, 1'b0, 16'h0000, pwX, 1'b0, 1'b1, 1'b0);
        asl_host_model_i.issue(8'hF7);
        op(OP_ERASE, 1'b1, 16'h0001, pwM, 1'b0, 1'b0, 1'b1);
        lk = 1'b0;
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            pw = (seed[2:1] == 2'b00) ? pwU : (seed[2:1] == 2'b01) ? pwM : pwX;
            ok = seed[ID_BIT] ? (pw === pwM) : (lk && pw === pwU);
            op(OP_DISABLE, 1'b1, seed, pw, !ok, lk && !ok, 1'b0);
            lk = lk && !ok;
            if (seed[3]) setpw(1'b0, pwU);
            if (seed[3]) lk = 1'b1;
        end
        wrap_up();
    end
endmodule
